//--- cbs_defs.vh
// Constants for the cell balance sequencer: register map, field layout, timing.
// Assumes inclusion by the single design file of the block.
`ifndef CBS_DEFS_VH
`define CBS_DEFS_VH

// ----------------------------------------------------------------------------
// Register addresses (6-bit register address space)
// ----------------------------------------------------------------------------
`define CBS_A_SETUP 6'h13
`define CBS_A_STATUS 6'h14
`define CBS_A_TIME 6'h15
`define CBS_A_FLAGS 6'h16
`define CBS_A_ACTIVE 6'h17
`define CBS_A_VAL_BASE 6'h20
`define CBS_A_VAL_END 6'h38

// ----------------------------------------------------------------------------
// Balance setup register fields
// ----------------------------------------------------------------------------
`define CBS_RUN_BIT 9
`define CBS_PTR_HI 8
`define CBS_PTR_LO 5
`define CBS_WAIT_HI 4
`define CBS_WAIT_LO 2
`define CBS_MODE_HI 1
`define CBS_MODE_LO 0

// Balance mode encodings
`define CBS_MODE_OFF 2'h0
`define CBS_MODE_MANUAL 2'h1
`define CBS_MODE_TIMED 2'h2
`define CBS_MODE_AUTO 2'h3

// On-time / watchdog register fields
`define CBS_ONT_HI 13
`define CBS_ONT_LO 7

// Flag register bits
`define CBS_FLAG_DONE 0
`define CBS_FLAG_WDOG 1

// ----------------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------------
`define CBS_CELLS 12
`define CBS_LOCS 13
`define CBS_FIRST_LOC 4'h1
`define CBS_LAST_LOC 4'hc
`define CBS_CLK_HZ 50000000
`define CBS_SEC_PER_TICK 20
`define CBS_TICK_LAST 5'h13

`endif

//--- cbs_sequencer.v
// Timed and automatic cell balance sequencer with sleep and watchdog handling.
// Assumes register writes, commands and scan results come from same-clock logic.
//
// Notes on behaviour
// R01: Mode 10 timed, mode 11 automatic balancing
// R02: Host sets pointer 0, writes cells first
// R03: On-time in 20 s steps; zero disables
// R04: Run bit or enable command restarts full time
// R05: Timed: clearing run stops outputs, resets timer
// R06: Timed expiry sets done flag, clears run
// R07: No balancing in sleep; sleep stops at once
// R08: Watchdog on: sleep stops now, flag later
// R09: Watchdog timeout: stop, sleep, set flag
// R10: Timer runs in sleep; wake resumes remainder
// R11: Auto instance drives its selected cells not yet zeroed
// R12: Instances from 1; zero instance wraps to 1
// R13: Host loads charge targets before auto start
// R14: On-time, then full scan, then wait time
// R15: Cycle until all zero; zeroed cell stops
// R16: Auto completion sets done flag, clears run
// R17: Auto inhibit keeps values; restart at 1
// R18: Run bit 9, mode field bits 1:0
// R19: Wait codes give 0,1,2,4..64 seconds
// R20: After on-time subtract measurement per balanced cell
// R21: Wake resumes auto with held values
// R22: Timer counts 20 s ticks against field
`timescale 1ns/1ps
`include "cbs_defs.vh"

module cbs_sequencer #(
	parameter SEC_CYCLES = 50000000 // Clock cycles per second
) (
	// Clock and reset
	input wire core_clk_i,
	input wire srst_i,
	// Register access
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [5:0] reg_addr_i,
	input wire [13:0] reg_wdata_i,
	output reg [13:0] reg_rdata_o,
	// Commands
	input wire bal_enable_cmd_i,
	input wire bal_inhibit_cmd_i,
	input wire sleep_cmd_i,
	input wire wake_cmd_i,
	// Watchdog
	input wire wdog_on_i,
	input wire wdog_expire_i,
	// Measurement engine
	output reg scan_req_o,
	input wire scan_done_i,
	input wire meas_valid_i,
	input wire [3:0] meas_cell_i,
	input wire [13:0] meas_data_i,
	// Status and drivers
	output reg [11:0] cell_bal_o,
	output reg sleep_o,
	output reg balance_done_flag_o,
	output reg watchdog_expired_flag_o
);

	// ------------------------------------------------------------------------
	// State codes
	// ------------------------------------------------------------------------
	localparam [3:0] ST_IDLE = 4'h1; // Not sequencing
	localparam [3:0] ST_BAL = 4'h2; // On-time running
	localparam [3:0] ST_SCAN = 4'h4; // Waiting for scan
	localparam [3:0] ST_WAIT = 4'h8; // Wait between cycles

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	reg [9:0] setup; // Balance setup register
	reg [13:0] ont_wdog; // balance_on_time_and_watchdog
	reg [11:0] pat [0:`CBS_LOCS-1]; // Pattern instances
	reg [3:0] state; // Sequencer state
	reg [3:0] auto_ptr; // Active auto instance
	reg [11:0] last_pat; // Cells driven this cycle
	reg [31:0] presc; // One-second prescaler
	reg [4:0] sec_cnt; // Seconds within a tick
	reg [6:0] tick_cnt; // Elapsed on-time ticks
	reg [6:0] wait_cnt; // Elapsed wait seconds
	wire [27:0] val [0:`CBS_CELLS-1]; // Charge targets
	wire [11:0] val_nz; // Cell target not yet met

	// Field views
	wire run = setup[`CBS_RUN_BIT];
	wire [1:0] mode = setup[`CBS_MODE_HI:`CBS_MODE_LO];
	wire [3:0] host_ptr = setup[`CBS_PTR_HI:`CBS_PTR_LO];
	wire [2:0] wait_code = setup[`CBS_WAIT_HI:`CBS_WAIT_LO];
	wire [6:0] on_time = ont_wdog[`CBS_ONT_HI:`CBS_ONT_LO];
	wire is_timed = (mode == `CBS_MODE_TIMED); // [R01]
	wire is_auto = (mode == `CBS_MODE_AUTO); // [R01]

	// Second and tick pulses
	wire sec_pulse = (presc == SEC_CYCLES - 1);
	wire tick_pulse = sec_pulse && (sec_cnt == `CBS_TICK_LAST); // [R22]

	// Wait target in seconds: 0,1,2,4,...,64
	wire [6:0] wait_secs = (wait_code == 3'h0) ? 7'h00 :
		(7'h01 << (wait_code - 3'h1)); // [R19]

	// Host writes to the run bit
	wire setup_wr = reg_wr_i && (reg_addr_i == `CBS_A_SETUP);
	wire run_wr_set = setup_wr && reg_wdata_i[`CBS_RUN_BIT];
	wire run_wr_clr = setup_wr && !reg_wdata_i[`CBS_RUN_BIT];
	wire start = run_wr_set || bal_enable_cmd_i; // [R04]
	wire stop = run_wr_clr || bal_inhibit_cmd_i; // [R05] [R17]

	// Timed expiry; zero code means no time limit
	wire on_expire = (on_time != 7'h00) && tick_pulse &&
		(tick_cnt == on_time - 7'h01); // [R03] [R22]
	wire timed_done = run && is_timed && (state == ST_BAL) && on_expire; // [R06]

	// Watchdog runout whenever the watchdog is on, in any state, awake or asleep
	wire wdog_hit = wdog_on_i && wdog_expire_i;

	// Next auto location: wrap on zero instance or past the last
	wire [3:0] ptr_inc = auto_ptr + 4'h1;
	wire [3:0] next_ptr = ((auto_ptr == `CBS_LAST_LOC) || (pat[ptr_inc] == 12'h000)) ?
		`CBS_FIRST_LOC : ptr_inc; // [R12]
	wire auto_all_zero = (val_nz == 12'h000); // [R15]
	// Auto completion: every target met while between cycles
	wire auto_fin = run && is_auto && (state == ST_WAIT) && auto_all_zero; // [R16]

	// ------------------------------------------------------------------------
	// Charge target registers, one per cell
	// ------------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `CBS_CELLS; g = g + 1) begin : g_cell
			localparam [5:0] A_LO = `CBS_A_VAL_BASE + 2 * g; // Low half address
			localparam [5:0] A_HI = `CBS_A_VAL_BASE + 2 * g + 1; // High half address
			reg [27:0] v; // Remaining charge target
			wire hit = meas_valid_i && (meas_cell_i == g) && last_pat[g] &&
				(state == ST_SCAN); // [R20]
			// Host load, else subtract the measured voltage, floor at zero
			always @(posedge core_clk_i) begin
				if (srst_i) begin
					v <= 28'h0000000;
				end else if (reg_wr_i && reg_addr_i == A_LO) begin
					v[13:0] <= reg_wdata_i; // [R13]
				end else if (reg_wr_i && reg_addr_i == A_HI) begin
					v[27:14] <= reg_wdata_i; // [R13]
				end else if (hit) begin
					v <= (v > {14'h0000, meas_data_i}) ? v - {14'h0000, meas_data_i} :
						28'h0000000; // [R20]
				end
			end
			assign val[g] = v;
			assign val_nz[g] = (v != 28'h0000000); // [R15]
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Configuration registers and pattern instances
	// ------------------------------------------------------------------------
	// Host writes; hardware clears run on timed or auto completion
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			setup <= 10'h000;
			ont_wdog <= 14'h0000;
		end else begin
			if (setup_wr) begin
				setup <= reg_wdata_i[9:0]; // [R18]
			end else if (bal_enable_cmd_i) begin
				setup[`CBS_RUN_BIT] <= 1'b1; // [R04]
			end else if (bal_inhibit_cmd_i) begin
				setup[`CBS_RUN_BIT] <= 1'b0; // [R05]
			end
			if (reg_wr_i && reg_addr_i == `CBS_A_TIME) begin
				ont_wdog <= reg_wdata_i;
			end
			// Completion clears run unless the host writes setup or enables this cycle
			if (!setup_wr && !bal_enable_cmd_i && (timed_done || auto_fin)) begin
				setup[`CBS_RUN_BIT] <= 1'b0; // [R06] [R16]
			end
		end
	end

	// Pattern instance write at the host pointer
	integer i;
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			for (i = 0; i < `CBS_LOCS; i = i + 1) begin
				pat[i] <= 12'h000;
			end
		end else if (reg_wr_i && reg_addr_i == `CBS_A_STATUS && host_ptr <= `CBS_LAST_LOC) begin
			pat[host_ptr] <= reg_wdata_i[11:0]; // [R02] [R12]
		end
	end

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	// State, timers, pointer, sleep and scan request
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			state <= ST_IDLE;
			auto_ptr <= `CBS_FIRST_LOC;
			last_pat <= 12'h000;
			presc <= 32'h00000000;
			sec_cnt <= 5'h00;
			tick_cnt <= 7'h00;
			wait_cnt <= 7'h00;
			sleep_o <= 1'b0;
			scan_req_o <= 1'b0;
		end else begin
			scan_req_o <= 1'b0;
			// Prescaler always runs so timed balancing ages in sleep
			presc <= sec_pulse ? 32'h00000000 : presc + 32'h00000001; // [R10]
			if (sec_pulse) begin
				sec_cnt <= (sec_cnt == `CBS_TICK_LAST) ? 5'h00 : sec_cnt + 5'h01;
			end
			// Sleep entry on command or watchdog; wake leaves
			if (sleep_cmd_i || wdog_hit) begin
				sleep_o <= 1'b1; // [R07] [R08] [R09]
			end else if (wake_cmd_i) begin
				sleep_o <= 1'b0; // [R10] [R21]
			end
			if (start) begin
				// Fresh start: full on-time, first auto location
				state <= ST_BAL; // [R04]
				presc <= 32'h00000000;
				sec_cnt <= 5'h00;
				tick_cnt <= 7'h00;
				auto_ptr <= `CBS_FIRST_LOC; // [R17]
				last_pat <= 12'h000;
			end else if (stop || !(is_timed || is_auto)) begin
				state <= ST_IDLE; // [R05] [R17]
				tick_cnt <= 7'h00; // [R05]
			end else begin
				case (state)
					ST_IDLE: begin
						state <= ST_IDLE;
					end
					ST_BAL: begin
						if (is_timed) begin
							// Timed: count through sleep too
							if (on_expire) begin
								state <= ST_IDLE; // [R06] [R10]
							end else if (tick_pulse) begin
								tick_cnt <= tick_cnt + 7'h01; // [R22]
							end
						end else if (!sleep_o) begin
							// Auto: frozen while asleep
							last_pat <= pat[auto_ptr]; // [R11]
							if (on_expire) begin
								state <= ST_SCAN; // [R14]
								scan_req_o <= 1'b1; // [R14]
								tick_cnt <= 7'h00;
							end else if (tick_pulse) begin
								tick_cnt <= tick_cnt + 7'h01;
							end
						end
					end
					ST_SCAN: begin
						if (scan_done_i) begin
							state <= ST_WAIT; // [R14]
							wait_cnt <= 7'h00;
						end
					end
					ST_WAIT: begin
						if (auto_all_zero) begin
							state <= ST_IDLE; // [R15] [R16]
						end else if (!sleep_o && wait_cnt >= wait_secs) begin
							state <= ST_BAL; // [R14]
							auto_ptr <= next_ptr; // [R12]
							presc <= 32'h00000000;
							sec_cnt <= 5'h00;
							tick_cnt <= 7'h00;
						end else if (!sleep_o && sec_pulse) begin
							wait_cnt <= wait_cnt + 7'h01; // [R19]
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Drivers and flags
	// ------------------------------------------------------------------------
	// Drive cells only while awake, running and in the on-time
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			cell_bal_o <= 12'h000;
		end else if (run && !sleep_o && !(sleep_cmd_i || wdog_hit) && !stop &&
			state == ST_BAL && !on_expire) begin // Off on the expiry edge [R06] [R14]
			if (is_timed) begin
				cell_bal_o <= pat[0]; // [R02] [R07]
			end else begin
				cell_bal_o <= pat[auto_ptr] & val_nz; // [R11] [R15]
			end
		end else begin
			cell_bal_o <= 12'h000; // [R05] [R07] [R08] [R09]
		end
	end

	// Sticky flags; a set in the clearing cycle wins
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			balance_done_flag_o <= 1'b0;
			watchdog_expired_flag_o <= 1'b0;
		end else begin
			if (timed_done || auto_fin) begin
				balance_done_flag_o <= 1'b1; // [R06] [R16]
			end else if (reg_wr_i && reg_addr_i == `CBS_A_FLAGS &&
				!reg_wdata_i[`CBS_FLAG_DONE]) begin
				balance_done_flag_o <= 1'b0;
			end
			if (wdog_hit) begin
				watchdog_expired_flag_o <= 1'b1; // [R08] [R09]
			end else if (reg_wr_i && reg_addr_i == `CBS_A_FLAGS &&
				!reg_wdata_i[`CBS_FLAG_WDOG]) begin
				watchdog_expired_flag_o <= 1'b0;
			end
		end
	end

	// Registered read data, unmapped reads as zero
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= 14'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`CBS_A_SETUP: reg_rdata_o <= {4'h0, setup};
				`CBS_A_STATUS: reg_rdata_o <= (host_ptr <= `CBS_LAST_LOC) ?
					{2'h0, pat[host_ptr]} : 14'h0000;
				`CBS_A_TIME: reg_rdata_o <= ont_wdog;
				`CBS_A_FLAGS: reg_rdata_o <= {12'h000, watchdog_expired_flag_o,
					balance_done_flag_o};
				`CBS_A_ACTIVE: reg_rdata_o <= {2'h0, cell_bal_o};
				default: begin
					if (reg_addr_i >= `CBS_A_VAL_BASE && reg_addr_i < `CBS_A_VAL_END) begin
						reg_rdata_o <= reg_addr_i[0] ? val[reg_addr_i[4:1]][27:14] :
							val[reg_addr_i[4:1]][13:0];
					end else begin
						reg_rdata_o <= 14'h0000;
					end
				end
			endcase
		end
	end

endmodule // cbs_sequencer

//--- cbs_sequencer_properties.sv
// Checker for the balance sequencer: stop, flag and scan relations.
// Assumes a bind to the sequencer top module, one clock domain.
`timescale 1ns/1ps
module cbs_sequencer_props (
	// Clock and reset
	input wire core_clk_i,
	input wire srst_i,
	// Inputs watched
	input wire reg_wr_i,
	input wire [5:0] reg_addr_i,
	input wire [13:0] reg_wdata_i,
	input wire bal_inhibit_cmd_i,
	input wire sleep_cmd_i,
	input wire wdog_on_i,
	input wire wdog_expire_i,
	// Outputs watched
	input wire scan_req_o,
	input wire [11:0] cell_bal_o,
	input wire sleep_o,
	input wire balance_done_flag_o,
	input wire watchdog_expired_flag_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// ----------------------------------------
	// Helper terms
	// ----------------------------------------
	wire flag_wr = reg_wr_i && reg_addr_i == 6'h16; // Flag register write
	wire done_kept = balance_done_flag_o && !(flag_wr && !reg_wdata_i[0]); // Kept set
	wire wdog_kept = watchdog_expired_flag_o && !(flag_wr && !reg_wdata_i[1]); // Kept set
	wire drv_off = cell_bal_o == 12'h000; // No cell driven
	sequence s_trip; wdog_on_i && wdog_expire_i; endsequence
	sequence s_halted; sleep_o && cell_bal_o == 12'h000 && watchdog_expired_flag_o; endsequence
	sequence s_dark; sleep_o && cell_bal_o == 12'h000; endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_wdog_trip_halts: assert property (s_trip |=> s_halted)
		else $error("watchdog expiry did not halt and flag");
	a_sleep_cmd_dark: assert property (sleep_cmd_i |=> s_dark)
		else $error("sleep command left drivers on");
	a_sleep_stays_dark: assert property (sleep_o && $past(sleep_o) |-> cell_bal_o == 12'h000)
		else $error("drivers on while asleep");
	a_inhibit_stops_all: assert property (bal_inhibit_cmd_i |=> cell_bal_o == 12'h000)
		else $error("inhibit left drivers on");
	a_scan_one_pulse: assert property (scan_req_o |=> !scan_req_o)
		else $error("scan request longer than one cycle");
	a_scan_drivers_off: assert property (scan_req_o |-> cell_bal_o == 12'h000)
		else $error("drivers on during scan request");
	a_done_stays_set: assert property (done_kept |=> balance_done_flag_o)
		else $error("done flag dropped without clear");
	a_wdog_flag_sticky: assert property (wdog_kept |=> watchdog_expired_flag_o)
		else $error("watchdog flag dropped without clear");
	a_done_stops_drive: assert property ($rose(balance_done_flag_o) |-> drv_off)
		else $error("drivers on after end of balance");
endmodule // cbs_sequencer_props

bind cbs_sequencer cbs_sequencer_props chk_u (.core_clk_i(core_clk_i), .srst_i(srst_i),
	.reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.bal_inhibit_cmd_i(bal_inhibit_cmd_i), .sleep_cmd_i(sleep_cmd_i), .wdog_on_i(wdog_on_i),
	.wdog_expire_i(wdog_expire_i), .scan_req_o(scan_req_o), .cell_bal_o(cell_bal_o),
	.sleep_o(sleep_o), .balance_done_flag_o(balance_done_flag_o),
	.watchdog_expired_flag_o(watchdog_expired_flag_o));

//--- cbs_meas_engine.sv
// Measurement engine model: answers a scan request with twelve readings.
// Assumes the sequencer clock; readings are a fixed value per cell.
`timescale 1ns/1ps
module cbs_meas_engine #(
	parameter [13:0] MEAS = 14'h0002 // Value reported per cell
) (
	// Clock and reset
	input wire core_clk_i,
	input wire srst_i,
	// Scan handshake
	input wire scan_req_i,
	output wire scan_done_o,
	output wire meas_valid_o,
	output wire [3:0] meas_cell_o,
	output wire [13:0] meas_data_o
);
	reg [4:0] step; // 1..12 reading, 13 done
	// Step through cells after a request
	always @(posedge core_clk_i) begin
		if (srst_i)
			step <= 5'h00;
		else if (scan_req_i)
			step <= 5'h01;
		else if (step != 5'h00)
			step <= (step == 5'h0d) ? 5'h00 : step + 5'h01;
	end
	assign meas_valid_o = step != 5'h00 && step < 5'h0d;
	assign meas_cell_o = step[3:0] - 4'h1;
	assign scan_done_o = step == 5'h0d;
	// Data line shows junk outside a reading
	assign meas_data_o = meas_valid_o ? MEAS : ~MEAS;
endmodule // cbs_meas_engine

//--- cbs_sequencer_tb.sv
// Testbench for the balance sequencer: timed, sleep, watchdog, automatic.
// Assumes a shortened second (5 cycles), so a 20 s tick is 100 cycles.
`timescale 1ns/1ps
module cbs_sequencer_tb;
	reg clk, rst, wr, rd, en, inh, slp, wk, wd_on, wd_exp;
	reg [5:0] addr;
	reg [13:0] wdata, v;
	wire [13:0] rdata, mdata;
	wire [11:0] bal;
	wire scan, sdone, mval, sleep_s, done_f, wd_f;
	wire [3:0] mcell;
	integer fail_count, samples_checked, n;
	cbs_sequencer #(.SEC_CYCLES(5)) dut_u (.core_clk_i(clk), .srst_i(rst), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.bal_enable_cmd_i(en), .bal_inhibit_cmd_i(inh), .sleep_cmd_i(slp), .wake_cmd_i(wk),
		.wdog_on_i(wd_on), .wdog_expire_i(wd_exp), .scan_req_o(scan), .scan_done_i(sdone),
		.meas_valid_i(mval), .meas_cell_i(mcell), .meas_data_i(mdata), .cell_bal_o(bal),
		.sleep_o(sleep_s), .balance_done_flag_o(done_f), .watchdog_expired_flag_o(wd_f));
	cbs_meas_engine meas_u (.core_clk_i(clk), .srst_i(rst), .scan_req_i(scan),
		.scan_done_o(sdone), .meas_valid_o(mval), .meas_cell_o(mcell), .meas_data_o(mdata));
	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", samples_checked, fail_count);
			if (fail_count == 0 && samples_checked > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task chk(input [13:0] got, input [13:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wrr(input [5:0] a, input [13:0] d);
		begin
			@(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
			@(posedge clk) wr <= 1'b0;
		end
	endtask
	task rdr(input [5:0] a);
		begin
			@(posedge clk) begin rd <= 1'b1; addr <= a; end
			@(posedge clk) rd <= 1'b0;
			@(posedge clk) #1 v = rdata;
		end
	endtask
	// Command pulse: enable, inhibit, sleep, wake
	task cmd(input [3:0] c);
		begin
			@(posedge clk) {en, inh, slp, wk} <= c;
			@(posedge clk) {en, inh, slp, wk} <= 4'h0;
			@(posedge clk) #1;
		end
	endtask
	// Wait, bounded, for a driver pattern
	task waitb(input [11:0] e);
		begin
			n = 0;
			while (bal !== e && n < 400) begin
				@(posedge clk) #1 n = n + 1;
			end
			chk({2'h0, bal}, {2'h0, e});
		end
	endtask
	// Watchdog
	initial begin
		#200000;
		fail_count = fail_count + 1;
		give_verdict;
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		fail_count = 0; samples_checked = 0;
		{rst, wr, rd, en, inh, slp, wk, wd_on, wd_exp} = 9'h100;
		addr = 6'h00; wdata = 14'h0000;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdr(6'h13); chk(v, 14'h0000);
		rdr(6'h3f); chk(v, 14'h0000);
		// Timed: pointer 0, cells 5 and 7, one tick
		wrr(6'h13, 14'h0002); wrr(6'h14, 14'h00a0); wrr(6'h15, 14'h0080);
		wrr(6'h13, 14'h0202);
		waitb(12'h0a0);
		n = 0;
		while (!done_f && n < 300) begin
			@(posedge clk) #1 n = n + 1;
		end
		chk({13'h0, n > 95 && n < 105}, 14'h0001);
		chk({2'h0, bal}, 14'h0000);
		rdr(6'h13); chk(v, 14'h0002);
		// Inhibit then sleep and wake
		cmd(4'h8); waitb(12'h0a0);
		cmd(4'h4); chk({2'h0, bal}, 14'h0000);
		cmd(4'h8); waitb(12'h0a0);
		cmd(4'h2); chk({12'h0, sleep_s, bal[5]}, 14'h0002);
		cmd(4'h1); waitb(12'h0a0);
		// Timer runs out while asleep
		cmd(4'h2); repeat (150) @(posedge clk);
		cmd(4'h1); repeat (3) @(posedge clk);
		chk({2'h0, bal}, 14'h0000);
		// Watchdog on: sleep stops now, flag only on expiry; then expiry while balancing
		wrr(6'h16, 14'h0000); rdr(6'h16); chk(v, 14'h0000);
		@(posedge clk) wd_on <= 1'b1;
		cmd(4'h8); waitb(12'h0a0);
		cmd(4'h2); chk({11'h0, wd_f, sleep_s, bal[5]}, 14'h0002);
		@(posedge clk) wd_exp <= 1'b1;
		@(posedge clk) wd_exp <= 1'b0;
		#1 chk({11'h0, wd_f, sleep_s, bal[5]}, 14'h0006);
		wrr(6'h16, 14'h0000); cmd(4'h1); waitb(12'h0a0);
		@(posedge clk) wd_exp <= 1'b1;
		@(posedge clk) wd_exp <= 1'b0;
		#1 chk({11'h0, wd_f, sleep_s, bal[5]}, 14'h0006);
		cmd(4'h1); cmd(4'h4);
		@(posedge clk) wd_on <= 1'b0;
		wrr(6'h16, 14'h0000);
		// Automatic: patterns 1 and 2, zero at 3
		wrr(6'h13, 14'h0023); wrr(6'h14, 14'h0005);
		wrr(6'h13, 14'h0043); wrr(6'h14, 14'h000a);
		wrr(6'h13, 14'h0063); wrr(6'h14, 14'h0000);
		wrr(6'h20, 14'h0004); wrr(6'h22, 14'h0002);
		wrr(6'h24, 14'h0002); wrr(6'h26, 14'h0002);
		wrr(6'h13, 14'h020f); // Run, auto, 4 s wait
		waitb(12'h005);
		waitb(12'h00a);
		waitb(12'h001);
		cmd(4'h4); rdr(6'h20); chk(v, 14'h0002);
		cmd(4'h8); waitb(12'h001);
		n = 0;
		while (!done_f && n < 400) begin
			@(posedge clk) #1 n = n + 1;
		end
		chk({13'h0, done_f}, 14'h0001);
		rdr(6'h13); chk(v & 14'h0200, 14'h0000);
		give_verdict;
	end
endmodule // cbs_sequencer_tb
